// ===== rtl/dee_consts.vh
// constants for the data eeprom access controller
`ifndef DEE_CONSTS_VH
`define DEE_CONSTS_VH
`define DEE_CSR_ADDR 16'h0030
`define DEE_CSR_RESET 8'h00
`define DEE_BIT_PROGRAM 0
`define DEE_BIT_LATCH 1
`define DEE_ERASE_CYCLES 32'd200
`define DEE_PROG_CYCLES 32'd200
`define DEE_WIPE_CYCLES 32'd200
`endif

// ===== rtl/dee_latches.v
// data latch bank with write masks
`timescale 1ns/1ps
module dee_latches #(
  parameter ROW_BYTES = 32,
  parameter COL_W = 5
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // control
  input wire clear, // drop all latched bytes
  input wire wr_en, // latch one byte
  input wire [COL_W-1:0] wr_col,
  input wire [7:0] wr_data,
  // contents
  output wire [ROW_BYTES*8-1:0] data,
  output wire [ROW_BYTES-1:0] valid
);
  reg [7:0] byte_r [0:ROW_BYTES-1]; // latched byte per column
  reg [ROW_BYTES-1:0] valid_r; // column written since last clear
  genvar g;
  // one latch per column; cleared latches hold ff so AND starts neutral
  generate
    for (g = 0; g < ROW_BYTES; g = g + 1)
    begin : g_lat
      always @(posedge clk_sys)
      begin
        if (!rst_n || clear)
        begin
          byte_r[g] <= 8'hff;
          valid_r[g] <= 1'b0;
        end
        else if (wr_en && wr_col == g)
        begin
          byte_r[g] <= byte_r[g] & wr_data;
          valid_r[g] <= 1'b1;
        end
      end
      assign data[g*8 +: 8] = byte_r[g];
    end
  endgenerate
  assign valid = valid_r;
endmodule // dee_latches

// ===== rtl/dee_array.v
// nonvolatile cell array model with byte read and row program
`timescale 1ns/1ps
module dee_array #(
  parameter DEPTH = 128,
  parameter AW = 7,
  parameter ROW_BYTES = 32,
  parameter COL_W = 5
) (
  // clock
  input wire clk_sys,
  // read port
  input wire [AW-1:0] rd_addr,
  output reg [7:0] rd_data,
  // row write port
  input wire row_we, // commit latched bytes to a row
  input wire [AW-COL_W-1:0] row_sel,
  input wire [ROW_BYTES*8-1:0] row_data,
  input wire [ROW_BYTES-1:0] row_mask,
  // whole array erase
  input wire wipe
);
  reg [7:0] mem [0:DEPTH-1]; // cell storage, not reset: nonvolatile
  genvar g;
  // registered read gives the byte on the next edge
  always @(posedge clk_sys)
  begin
    rd_data <= mem[rd_addr];
  end
  // each cell updates on wipe or on a row write to its row with its column masked in
  generate
    for (g = 0; g < DEPTH; g = g + 1)
    begin : g_cell
      always @(posedge clk_sys)
      begin
        if (wipe)
        begin
          mem[g] <= 8'hff;
        end
        else if (row_we && row_sel == (g >> COL_W) && row_mask[g % ROW_BYTES])
        begin
          mem[g] <= row_data[(g % ROW_BYTES)*8 +: 8];
        end
      end
    end
  endgenerate
endmodule // dee_array

// ===== rtl/dee_ctrl.v
// data eeprom access controller top
`include "dee_consts.vh"
`timescale 1ns/1ps
module dee_ctrl #(
  parameter DEPTH = 128,
  parameter AW = 7,
  parameter ROW_BYTES = 32,
  parameter COL_W = 5,
  parameter [15:0] ARRAY_BASE = 16'h1000,
  parameter [31:0] ERASE_CYCLES = `DEE_ERASE_CYCLES,
  parameter [31:0] PROG_CYCLES = `DEE_PROG_CYCLES,
  parameter [31:0] WIPE_CYCLES = `DEE_WIPE_CYCLES
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // cpu memory bus
  input wire [15:0] bus_addr,
  input wire bus_rd,
  input wire bus_wr,
  input wire bus_fetch,
  input wire [7:0] bus_wdata,
  output reg [7:0] bus_rdata,
  output reg bus_rdata_oe_n,
  output reg bus_fetch_err,
  // power modes
  input wire wait_req,
  input wire halt_req,
  output reg wait_ack,
  // protection option
  input wire protect_on,
  input wire ext_access,
  input wire unprotect_req,
  output reg wipe_busy,
  // status
  output reg prog_busy
);
  // sequencer states
  localparam SQ_IDLE = 2'd0; // no cycle
  localparam SQ_ERASE = 2'd1; // erase phase
  localparam SQ_PROG = 2'd2; // program phase
  localparam SQ_WIPE = 2'd3; // full erase on unprotect
  // sequencer and counter
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [31:0] cnt_r; // cycles left in the current phase
  reg [31:0] cnt_nxt;
  // control/status bits
  reg latch_mode_r; // write mode bit
  reg latch_mode_nxt;
  reg program_r; // program control bit
  reg program_nxt;
  reg [AW-COL_W-1:0] row_r; // row of last latched write
  reg [AW-COL_W-1:0] row_nxt;
  // read pipeline and power state
  reg rd_pend_r; // array read waiting for data
  reg csr_rd_r; // register read waiting
  reg rd_ok_r; // read may drive bus
  reg wait_r; // wait mode reached
  // decode and datapath nets
  wire in_array;
  wire hit_csr;
  wire row_we;
  wire latch_clear;
  wire latch_wr;
  wire wipe;
  wire [7:0] arr_rdata;
  wire [ROW_BYTES*8-1:0] latch_data;
  wire [ROW_BYTES-1:0] latch_valid;
  wire csr_wr;
  wire [7:0] csr_val;
  // address decode
  assign in_array = bus_addr >= ARRAY_BASE && bus_addr < ARRAY_BASE + DEPTH;
  assign hit_csr = bus_addr == `DEE_CSR_ADDR;
  assign csr_wr = bus_wr && hit_csr;
  // latch only in write mode, before programming, never when protected externally
  assign latch_wr = bus_wr && in_array && latch_mode_r && !program_r
    && !(protect_on && ext_access);
  // commit at end of program phase
  assign row_we = state_r == SQ_PROG && cnt_r == 32'd1;
  // latch clear on cycle end, or write mode falling
  assign latch_clear = row_we || (latch_mode_r && !latch_mode_nxt);
  assign wipe = state_r == SQ_WIPE;
  // reserved bits are constant zero, so writes to them have nowhere to land
  assign csr_val = {6'h00, latch_mode_r, program_r};
  // control/status register and sequencer next state
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    latch_mode_nxt = latch_mode_r;
    program_nxt = program_r;
    row_nxt = row_r;
    // the last latched write picks the row; software keeps writes in one row
    if (latch_wr)
    begin
      row_nxt = bus_addr[AW-1:COL_W];
    end
    if (csr_wr)
    begin
      // software clear of write mode is ignored while a program cycle runs, not during a wipe
      if (!bus_wdata[`DEE_BIT_LATCH] && !program_r)
      begin
        latch_mode_nxt = 1'b0;
      end
      if (bus_wdata[`DEE_BIT_PROGRAM] && (latch_mode_r || bus_wdata[`DEE_BIT_LATCH])
        && state_r == SQ_IDLE)
      begin
        program_nxt = 1'b1;
        state_nxt = SQ_ERASE;
        cnt_nxt = ERASE_CYCLES;
      end
      else if (!bus_wdata[`DEE_BIT_PROGRAM] && program_r)
      begin
        // abort: cells keep what they had, which counts as undefined
        program_nxt = 1'b0;
        state_nxt = SQ_IDLE;
        cnt_nxt = 32'd0;
      end
    end
    case (state_r)
      SQ_IDLE:
      begin
        if (unprotect_req)
        begin
          state_nxt = SQ_WIPE;
          cnt_nxt = WIPE_CYCLES;
        end
      end
      SQ_ERASE:
      begin
        // erase runs first, chained into program with no software step
        if (program_nxt)
        begin
          cnt_nxt = cnt_r - 32'd1;
          if (cnt_r == 32'd1)
          begin
            state_nxt = SQ_PROG;
            cnt_nxt = PROG_CYCLES;
          end
        end
      end
      SQ_PROG:
      begin
        if (program_nxt)
        begin
          cnt_nxt = cnt_r - 32'd1;
          if (cnt_r == 32'd1)
          begin
            state_nxt = SQ_IDLE;
            program_nxt = 1'b0;
            latch_mode_nxt = 1'b0;
          end
        end
      end
      SQ_WIPE:
      begin
        cnt_nxt = cnt_r - 32'd1;
        if (cnt_r == 32'd1)
        begin
          state_nxt = SQ_IDLE;
        end
      end
      default:
      begin
        state_nxt = SQ_IDLE;
      end
    endcase
    // halt stops any erase, program or wipe cycle at once, data may be corrupted
    if (halt_req)
    begin
      state_nxt = SQ_IDLE;
      program_nxt = 1'b0;
      cnt_nxt = 32'd0;
    end
    // a software set outranks a hardware clear landing in the same cycle
    if (csr_wr && bus_wdata[`DEE_BIT_LATCH])
    begin
      latch_mode_nxt = 1'b1;
    end
  end
  // state registers
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      state_r <= SQ_IDLE;
      cnt_r <= 32'd0;
      latch_mode_r <= 1'b0;
      program_r <= 1'b0;
      row_r <= {(AW-COL_W){1'b0}};
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      latch_mode_r <= latch_mode_nxt;
      program_r <= program_nxt;
      row_r <= row_nxt;
    end
  end
  // read pipeline: array data is ready one edge after the request
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      rd_pend_r <= 1'b0;
      csr_rd_r <= 1'b0;
      rd_ok_r <= 1'b0;
      bus_fetch_err <= 1'b0;
    end
    else
    begin
      // fetches never reach the array data path
      rd_pend_r <= bus_rd && in_array && !bus_fetch;
      csr_rd_r <= bus_rd && hit_csr;
      rd_ok_r <= !latch_mode_r && !(protect_on && ext_access) && state_r != SQ_WIPE;
      bus_fetch_err <= bus_fetch && in_array;
    end
  end
  // bus drive: registered, so the byte lands within the cpu cycle
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      bus_rdata <= 8'h00;
      bus_rdata_oe_n <= 1'b1;
    end
    else if (csr_rd_r)
    begin
      bus_rdata <= csr_val;
      bus_rdata_oe_n <= 1'b0;
    end
    else if (rd_pend_r && rd_ok_r)
    begin
      bus_rdata <= arr_rdata;
      bus_rdata_oe_n <= 1'b0;
    end
    else
    begin
      bus_rdata <= 8'h00;
      bus_rdata_oe_n <= 1'b1;
    end
  end
  // power modes and status outputs
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      wait_r <= 1'b0;
      wait_ack <= 1'b0;
      prog_busy <= 1'b0;
      wipe_busy <= 1'b0;
    end
    else
    begin
      // wait waits until the sequencer is idle, with no program or wipe cycle running
      wait_r <= wait_req && state_nxt == SQ_IDLE;
      wait_ack <= wait_r;
      // busy follows the next value so it reads one with the bit itself
      prog_busy <= program_nxt;
      wipe_busy <= state_nxt == SQ_WIPE;
    end
  end
  // latch bank: cleared latches hold all ones so repeated writes AND
  dee_latches #(
    .ROW_BYTES(ROW_BYTES),
    .COL_W(COL_W)
  ) u_latches (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(latch_clear),
    .wr_en(latch_wr),
    .wr_col(bus_addr[COL_W-1:0]),
    .wr_data(bus_wdata),
    .data(latch_data),
    .valid(latch_valid)
  );
  // cell array: only columns written since the last clear are committed
  dee_array #(
    .DEPTH(DEPTH),
    .AW(AW),
    .ROW_BYTES(ROW_BYTES),
    .COL_W(COL_W)
  ) u_arr (
    .clk_sys(clk_sys),
    .rd_addr(bus_addr[AW-1:0]),
    .rd_data(arr_rdata),
    .row_we(row_we),
    .row_sel(row_r),
    .row_data(latch_data),
    .row_mask(latch_valid),
    .wipe(wipe)
  );
endmodule // dee_ctrl

// ===== test/dee_ctrl_monitor.sv
// concurrent checks on the eeprom controller ports
`timescale 1ns/1ps
module dee_ctrl_monitor #(
  parameter DEPTH = 128,
  parameter [15:0] ARRAY_BASE = 16'h1000,
  parameter [31:0] ERASE_CYCLES = 32'd200,
  parameter [31:0] PROG_CYCLES = 32'd200
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // cpu bus
  input wire [15:0] bus_addr,
  input wire bus_rd,
  input wire bus_wr,
  input wire bus_fetch,
  input wire [7:0] bus_wdata,
  input wire [7:0] bus_rdata,
  input wire bus_rdata_oe_n,
  input wire bus_fetch_err,
  // modes and protection
  input wire wait_req,
  input wire halt_req,
  input wire wait_ack,
  input wire protect_on,
  input wire ext_access,
  input wire unprotect_req,
  input wire wipe_busy,
  input wire prog_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // array window decode
  wire in_arr = bus_addr >= ARRAY_BASE && bus_addr < ARRAY_BASE + DEPTH;
  // busy length counter; a stuck cycle shows up here
  reg [31:0] busy_r;
  always @(posedge clk_sys)
    busy_r <= (!rst_n || !prog_busy) ? 32'h0 : busy_r + 32'h1;
  sequence s_csr_rd;
    bus_rd && bus_addr == 16'h0030 ##2 !bus_rdata_oe_n;
  endsequence
  sequence s_go;
    bus_wr && bus_addr == 16'h0030 && bus_wdata == 8'h03 && !prog_busy && !halt_req;
  endsequence
  property p_csr_zero;
    s_csr_rd |-> bus_rdata[7:2] == 6'h0;
  endproperty
  a_csr_zero: assert property (p_csr_zero) else $error("reserved bits set");
  property p_go;
    s_go |=> prog_busy;
  endproperty
  a_go: assert property (p_go) else $error("cycle not started");
  property p_time;
    prog_busy |-> busy_r <= ERASE_CYCLES + PROG_CYCLES + 2;
  endproperty
  a_time: assert property (p_time) else $error("cycle too long");
  property p_fetch;
    bus_rd && bus_fetch && in_arr |=> bus_fetch_err;
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch not refused");
  property p_halt;
    halt_req |-> ##[1:2] !prog_busy;
  endproperty
  a_halt: assert property (p_halt) else $error("halt did not stop");
  property p_wait;
    $rose(wait_ack) |-> !prog_busy;
  endproperty
  a_wait: assert property (p_wait) else $error("wait while busy");
  property p_prot;
    protect_on && ext_access && bus_rd |-> ##2 bus_rdata_oe_n;
  endproperty
  a_prot: assert property (p_prot) else $error("protected read driven");
  property p_wipe;
    unprotect_req && protect_on |-> ##[1:2] wipe_busy;
  endproperty
  a_wipe: assert property (p_wipe) else $error("wipe not started");
  property p_quiet;
    bus_rdata_oe_n |-> bus_rdata == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("data while undriven");
endmodule // dee_ctrl_monitor
bind dee_ctrl dee_ctrl_monitor #(.DEPTH(DEPTH), .ARRAY_BASE(ARRAY_BASE),
  .ERASE_CYCLES(ERASE_CYCLES), .PROG_CYCLES(PROG_CYCLES)) mon (.*);

// ===== test/dee_cpu.sv
// cpu core model: drives bus cycles
`timescale 1ns/1ps
module dee_cpu (
  // clock
  input wire clk_sys,
  // cpu bus
  output reg [15:0] addr,
  output reg rd,
  output reg wr,
  output reg fetch,
  output reg [7:0] wdata,
  input wire [7:0] rdata,
  input wire oe_n
);
  initial {addr, rd, wr, fetch, wdata} = 27'h0;
  // one write; idle lines inverted so stale values never match
  task w(input [15:0] a_i, input [7:0] d_i);
  begin
    @(posedge clk_sys);
    addr <= a_i;
    wdata <= d_i;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    addr <= ~a_i;
    wdata <= ~d_i;
  end
  endtask
  // one read; answer stands for one cycle right after the edge after it is taken
  task r(input [15:0] a_i, input f_i, output [7:0] d_o, output o_o);
  begin
    @(posedge clk_sys);
    addr <= a_i;
    fetch <= f_i;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    fetch <= 1'b0;
    addr <= ~a_i;
    @(posedge clk_sys);
    #1;
    d_o = rdata;
    o_o = oe_n;
  end
  endtask
endmodule // dee_cpu

// ===== test/dee_ctrl_test.sv
// self-checking bench for the eeprom controller
`timescale 1ns/1ps
module dee_ctrl_test;
  localparam [15:0] C = 16'h0030;
  reg clk_sys, rst_n, wait_req, halt_req, protect_on, ext_access, unprotect_req;
  wire [15:0] a;
  wire rd, wr, f, oe_n, ferr, wack, wbusy, pbusy;
  wire [7:0] wd, rdat;
  reg [7:0] d;
  reg o;
  reg [47:0] rows [0:4];
  integer n_fail, n_tests, i, k;
  dee_ctrl #(.ERASE_CYCLES(32'd3), .PROG_CYCLES(32'd20), .WIPE_CYCLES(32'd3)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_addr(a), .bus_rd(rd), .bus_wr(wr),
    .bus_fetch(f), .bus_wdata(wd), .bus_rdata(rdat), .bus_rdata_oe_n(oe_n),
    .bus_fetch_err(ferr), .wait_req(wait_req), .halt_req(halt_req), .wait_ack(wack),
    .protect_on(protect_on), .ext_access(ext_access), .unprotect_req(unprotect_req),
    .wipe_busy(wbusy), .prog_busy(pbusy));
  dee_cpu cpu (.clk_sys(clk_sys), .addr(a), .rd(rd), .wr(wr), .fetch(f),
    .wdata(wd), .rdata(rdat), .oe_n(oe_n));
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task chk(input [8*5-1:0] nm, input [7:0] e, input [7:0] g);
  begin
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  // start a cycle, busy shows one edge later
  task go;
  begin
    cpu.w(C, 8'h03);
    @(posedge clk_sys);
    #1;
    chk("busy", 8'h01, {7'h0, pbusy});
  end
  endtask
  // bounded wait for the cycle to end
  task idle;
  begin
    k = 0;
    while (pbusy !== 1'b0 && k < 60)
    begin
      @(posedge clk_sys);
      #1;
      k = k + 1;
    end
    chk("idle", 8'h00, {7'h0, pbusy});
  end
  endtask
  task conclude;
  begin
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask
  initial
  begin
    #100000;
    n_fail = n_fail + 1;
    conclude;
  end
  initial
  begin
    {rst_n, wait_req, halt_req, protect_on, ext_access, unprotect_req} = 6'h0;
    n_fail = 0;
    n_tests = 0;
    // write addr, read addr, data, expected
    rows[0] = 48'h1022_1022_55_55;
    rows[1] = 48'h1020_1020_a5_a5;
    rows[2] = 48'h1021_1021_3c_30;
    rows[3] = 48'h1021_1021_f0_30;
    rows[4] = 48'h103f_103f_0f_0f;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    cpu.r(C, 1'b0, d, o);
    chk("rst", 8'h00, d);
    cpu.w(C, 8'h02);
    cpu.r(C, 1'b0, d, o);
    chk("lat", 8'h02, d);
    cpu.r(16'h1020, 1'b0, d, o);
    chk("oe", 8'h01, {7'h0, o});
    for (i = 0; i < 5; i = i + 1)
      cpu.w(rows[i][47:32], rows[i][15:8]);
    go;
    idle;
    cpu.r(C, 1'b0, d, o);
    chk("end", 8'h00, d);
    for (i = 0; i < 5; i = i + 1)
    begin
      cpu.r(rows[i][31:16], 1'b0, d, o);
      chk("cell", rows[i][7:0], d);
    end
    cpu.w(16'h1020, 8'h00);
    cpu.r(16'h1020, 1'b0, d, o);
    chk("ign", 8'ha5, d);
    cpu.w(C, 8'hfc);
    cpu.r(C, 1'b0, d, o);
    chk("rsv", 8'h00, d);
    cpu.w(C, 8'h02);
    go;
    cpu.w(C, 8'h01);
    cpu.r(C, 1'b0, d, o);
    chk("hold", 8'h03, d);
    cpu.w(C, 8'h02);
    idle;
    cpu.w(C, 8'h00);
    cpu.r(C, 1'b0, d, o);
    chk("clr", 8'h00, d);
    cpu.w(C, 8'h02);
    go;
    @(posedge clk_sys);
    wait_req <= 1'b1;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("wbsy", 8'h00, {7'h0, wack});
    idle;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("wait", 8'h01, {7'h0, wack});
    @(posedge clk_sys);
    wait_req <= 1'b0;
    cpu.w(C, 8'h02);
    go;
    @(posedge clk_sys);
    halt_req <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("halt", 8'h00, {7'h0, pbusy});
    @(posedge clk_sys);
    halt_req <= 1'b0;
    cpu.w(C, 8'h00);
    cpu.r(16'h1020, 1'b1, d, o);
    chk("ftch", 8'h01, {7'h0, o});
    @(posedge clk_sys);
    protect_on <= 1'b1;
    ext_access <= 1'b1;
    cpu.r(16'h1020, 1'b0, d, o);
    chk("prot", 8'h01, {7'h0, o});
    @(posedge clk_sys);
    ext_access <= 1'b0;
    unprotect_req <= 1'b1;
    @(posedge clk_sys);
    unprotect_req <= 1'b0;
    protect_on <= 1'b0;
    repeat (3) @(posedge clk_sys);
    for (k = 0; wbusy !== 1'b0 && k < 60; k = k + 1)
      @(posedge clk_sys);
    cpu.r(16'h1020, 1'b0, d, o);
    chk("wipe", 8'hff, d);
    // reset in mid-cycle: register back to its reset value
    cpu.w(C, 8'h02);
    go;
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    cpu.r(C, 1'b0, d, o);
    chk("rrst", 8'h00, d);
    conclude;
  end
endmodule // dee_ctrl_test
